// ### dv/dwupb_nv_store.sv
`timescale 1ns/1ps
module dwupb_nv_store (
   input  wire logic        clk_in,
   input  wire logic        go_in,
   output logic             valid_out,
   output logic [2:0]       slot_out,
   output logic [31:0]      data_out
);
   logic [2:0] n_q = 3'h0;
   initial begin
      valid_out = 1'b0;
      slot_out = 3'h0;
      data_out = 32'h0;
   end
   // replays slots 4..0 once per go; flag slot first
   always @(negedge clk_in) begin
      if (n_q != 3'h0) begin
         valid_out <= 1'b1;
         slot_out <= n_q - 3'h1;
         data_out <= (n_q == 3'h5) ? 32'h1 : {16'hbeef, 13'h0, n_q};
         n_q <= n_q - 3'h1;
      end else begin
         valid_out <= 1'b0;
         // idle data toggles, so every other idle cycle shows the last word again
         data_out <= ~data_out;
         if (go_in) n_q <= 3'h5;
      end
   end
endmodule : dwupb_nv_store

// ### dv/dwupb_param_bank_checker.sv
`timescale 1ns/1ps
`include "dwupb_defines.svh"
module dwupb_param_bank_checker (
   input wire logic                   clk_in,
   input wire logic                   rst_n_in,
   input wire logic                   ce_in,
   input wire logic                   param_rd_in,
   input wire logic                   param_wr_in,
   input wire dwupb_pkg::dwupb_addr_t param_addr_in,
   input wire dwupb_pkg::dwupb_word_t param_wdata_in,
   input wire logic                   param_ack_out,
   input wire logic                   param_err_out,
   input wire dwupb_pkg::dwupb_warn_t warn_cond_in,
   input wire logic                   fault_reset_in,
   input wire dwupb_pkg::dwupb_warn_t present_warn_out,
   input wire dwupb_pkg::dwupb_warn_t sticky_warn_out,
   input wire logic                   abs_move_req_in,
   input wire logic                   homing_done_in,
   input wire logic                   homing_required_out,
   input wire logic                   abs_move_reject_out
);
   import dwupb_pkg::*;
   localparam logic [15:0] VM = `DWUPB_WARN_VALID_MASK;
   localparam logic [15:0] AM = `DWUPB_WARN_AUTO_MASK;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence req_s;
      ce_in && (param_rd_in || param_wr_in);
   endsequence
   sequence flag_wr_s;
      ce_in && param_wr_in && param_addr_in == `DWUPB_ADDR_HOME_REQ
         && param_wdata_in <= `DWUPB_HOME_REQ_MAX;
   endsequence
   ack_pulse_a: assert property (req_s |=> param_ack_out)
      else $error("ack missing after request");
   ro_refuse_a: assert property (ce_in && param_wr_in
      && param_addr_in == `DWUPB_ADDR_STICKY |=> param_err_out)
      else $error("write to latched word not refused");
   present_map_a: assert property (
      (warn_cond_in & VM) == present_warn_out)
      else $error("present word mismatch");
   sticky_set_a: assert property (ce_in |=>
      (sticky_warn_out & $past(warn_cond_in & VM)) == $past(warn_cond_in & VM))
      else $error("warning not latched");
   sticky_hold_a: assert property (ce_in && !fault_reset_in |=>
      (sticky_warn_out & $past(sticky_warn_out & ~AM))
         == $past(sticky_warn_out & ~AM))
      else $error("latched warning lost");
   fault_clear_a: assert property (ce_in && fault_reset_in |=>
      sticky_warn_out == $past(warn_cond_in & VM))
      else $error("fault reset did not clear");
   auto_clear_a: assert property (ce_in |=>
      (sticky_warn_out & AM) == ($past(warn_cond_in) & AM))
      else $error("self-clearing bit wrong");
   rsvd_zero_a: assert property ((sticky_warn_out & ~VM) == 16'h0000)
      else $error("reserved latched bit set");
   reject_gate_a: assert property (abs_move_reject_out ==
      (abs_move_req_in && homing_required_out && !homing_done_in))
      else $error("absolute move gate wrong");
   flag_now_a: assert property (flag_wr_s |=>
      homing_required_out == $past(param_wdata_in[0]))
      else $error("homing flag write not applied");
endmodule : dwupb_param_bank_checker

bind dwupb_param_bank dwupb_param_bank_checker chk_i (.*);

// ### dv/dwupb_param_bank_tb.sv
`timescale 1ns/1ps
`include "dwupb_defines.svh"
module dwupb_param_bank_tb;
   import dwupb_pkg::*;
   logic clk_in = 0, rst_n_in = 0, ce_in = 1, go = 0;
   logic param_rd_in = 0, param_wr_in = 0, fault_reset_in = 0;
   logic homing_done_in = 0, abs_move_req_in = 0, restore_valid_in;
   logic param_ack_out, param_err_out, homing_required_out;
   logic abs_move_ok_out, abs_move_reject_out;
   dwupb_addr_t param_addr_in = 16'h0;
   dwupb_word_t param_wdata_in = 32'h0, restore_data_in, param_rdata_out;
   dwupb_word_t user_word_1_out, user_word_2_out;
   dwupb_word_t user_word_3_out, user_word_4_out;
   dwupb_slot_t restore_slot_in;
   dwupb_warn_t warn_cond_in = 16'h0, present_warn_out, sticky_warn_out;
   dwupb_util_t volt_util_in = 16'sh0064;
   int num_errors = 0, total_checks = 0, i;
   logic [31:0] es = 32'h0;
   dwupb_addr_t ua [4] = '{`DWUPB_ADDR_USER1, `DWUPB_ADDR_USER2,
                           `DWUPB_ADDR_USER3, `DWUPB_ADDR_USER4};
   always #5 clk_in = ~clk_in;
   dwupb_param_bank DUT (.*);
   dwupb_nv_store nv (.clk_in(clk_in), .go_in(go),
      .valid_out(restore_valid_in), .slot_out(restore_slot_in),
      .data_out(restore_data_in));
   // ------------------------------------------------------------
   // access helpers
   // ------------------------------------------------------------
   task summarize;
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk
   task acc(input logic w, input dwupb_addr_t a, input dwupb_word_t d,
            input logic e);
      int n;
      @(negedge clk_in);
      param_addr_in = a;
      param_wdata_in = d;
      param_rd_in = !w;
      param_wr_in = w;
      @(negedge clk_in);
      param_rd_in = 0;
      param_wr_in = 0;
      n = 0;
      while (param_ack_out !== 1'b1 && n < 4) begin
         @(negedge clk_in);
         n++;
      end
      if (param_ack_out !== 1'b1) begin
         num_errors++;
         summarize;
      end
      chk({31'h0, param_err_out}, {31'h0, e});
   endtask : acc
   task rd(input dwupb_addr_t a, input dwupb_word_t x);
      acc(0, a, 32'h0, 0);
      chk(param_rdata_out, x);
   endtask : rd
   initial begin
      repeat (4) @(negedge clk_in);
      rst_n_in = 1;
      for (i = 0; i < 4; i++) rd(ua[i], 32'h0);
      rd(`DWUPB_ADDR_HOME_REQ, 32'h0);
      for (i = 0; i < 4; i++) acc(1, ua[i], 32'hf00d_0000 + i, 0);
      for (i = 0; i < 4; i++) rd(ua[i], 32'hf00d_0000 + i);
      chk(user_word_3_out, 32'hf00d_0002);
      acc(1, `DWUPB_ADDR_STICKY, 32'h1, 1);
      acc(1, `DWUPB_ADDR_PRESENT, 32'h1, 1);
      acc(0, 16'h0000, 32'h0, 1);
      acc(1, `DWUPB_ADDR_HOME_REQ, 32'h2, 1);
      rd(`DWUPB_ADDR_VOLT_UTIL, 32'h0000_0064);
      volt_util_in = 16'shfffb;
      rd(`DWUPB_ADDR_VOLT_UTIL, 32'hffff_fffb);
      for (i = 0; i < 16; i++) begin
         warn_cond_in = 16'h0001 << i;
         es = ((es & ~32'h2c00) | (32'h1 << i)) & 32'h7ff7;
         @(negedge clk_in);
         chk({16'h0, present_warn_out}, 32'h7ff7 & (32'h1 << i));
         chk({16'h0, sticky_warn_out}, es);
      end
      warn_cond_in = 16'h0;
      rd(`DWUPB_ADDR_STICKY, 32'h53f7);
      rd(`DWUPB_ADDR_PRESENT, 32'h0);
      warn_cond_in = 16'h0002;
      fault_reset_in = 1;
      @(negedge clk_in);
      warn_cond_in = 16'h0;
      chk({16'h0, sticky_warn_out}, 32'h2);
      @(negedge clk_in);
      fault_reset_in = 0;
      chk({16'h0, sticky_warn_out}, 32'h0);
      // clock enable low must freeze the latched word
      ce_in = 0;
      warn_cond_in = 16'h0001;
      @(negedge clk_in);
      chk({16'h0, sticky_warn_out}, 32'h0);
      ce_in = 1;
      @(negedge clk_in);
      warn_cond_in = 16'h0;
      chk({16'h0, sticky_warn_out}, 32'h1);
      abs_move_req_in = 1;
      @(negedge clk_in);
      chk({30'h0, abs_move_ok_out, abs_move_reject_out}, 32'h2);
      acc(1, `DWUPB_ADDR_HOME_REQ, 32'h1, 0);
      chk({30'h0, abs_move_ok_out, abs_move_reject_out}, 32'h1);
      homing_done_in = 1;
      @(negedge clk_in);
      chk({30'h0, abs_move_ok_out, abs_move_reject_out}, 32'h2);
      rd(`DWUPB_ADDR_HOME_REQ, 32'h1);
      acc(1, `DWUPB_ADDR_HOME_REQ, 32'h0, 0);
      // held over two edges so the model's negedge sampling cannot miss it
      go = 1;
      repeat (2) @(negedge clk_in);
      go = 0;
      repeat (8) @(negedge clk_in);
      chk(user_word_1_out, 32'hbeef_0001);
      chk(user_word_2_out, 32'hbeef_0002);
      chk(user_word_4_out, 32'hbeef_0004);
      chk({31'h0, homing_required_out}, 32'h1);
      summarize;
   end
endmodule : dwupb_param_bank_tb

// ### include/dwupb_defines.svh
`ifndef DWUPB_DEFINES_SVH
`define DWUPB_DEFINES_SVH

// ---------------------------------------------------------------
// parameter addresses (fieldbus word addresses)
// ---------------------------------------------------------------
`define DWUPB_ADDR_USER1      16'h013e
`define DWUPB_ADDR_USER2      16'h0140
`define DWUPB_ADDR_USER3      16'h0142
`define DWUPB_ADDR_USER4      16'h0144
`define DWUPB_ADDR_HOME_REQ   16'h062c
`define DWUPB_ADDR_PRESENT    16'h1c16
`define DWUPB_ADDR_STICKY     16'h1c18
`define DWUPB_ADDR_VOLT_UTIL  16'h1e26

// ---------------------------------------------------------------
// reset values and homing flag write limit
// ---------------------------------------------------------------
`define DWUPB_RST_USER        32'h0000_0000
`define DWUPB_RST_HOME_REQ    1'h0
`define DWUPB_HOME_REQ_MAX    32'h0000_0001

// ---------------------------------------------------------------
// warning bit positions
// ---------------------------------------------------------------
`define DWUPB_WB_GENERAL      0
`define DWUPB_WB_STAGE_HOT    1
`define DWUPB_WB_MOTOR_HOT    2
`define DWUPB_WB_RSVD_LO      3
`define DWUPB_WB_STAGE_OVL    4
`define DWUPB_WB_MOTOR_OVL    5
`define DWUPB_WB_BRAKE_OVL    6
`define DWUPB_WB_CAN          7
`define DWUPB_WB_ENCODER      8
`define DWUPB_WB_RS485        9
`define DWUPB_WB_SAFE_TORQUE  10
`define DWUPB_WB_UNDERVOLT    11
`define DWUPB_WB_LEGACY_BUS   12
`define DWUPB_WB_CAPTURE      13
`define DWUPB_WB_ETHERNET     14
`define DWUPB_WB_RSVD_HI      15

// reserved bits held at zero, self-clearing bits
`define DWUPB_WARN_VALID_MASK 16'h7ff7
`define DWUPB_WARN_AUTO_MASK  16'h2c00
`define DWUPB_WARN_ZERO       16'h0000

// restore slot indices
`define DWUPB_SLOT_USER1      3'h0
`define DWUPB_SLOT_USER2      3'h1
`define DWUPB_SLOT_USER3      3'h2
`define DWUPB_SLOT_USER4      3'h3
`define DWUPB_SLOT_HOME_REQ   3'h4

`endif

// ### include/dwupb_pkg.sv
package dwupb_pkg;
   typedef logic [15:0]        dwupb_addr_t;
   typedef logic [31:0]        dwupb_word_t;
   typedef logic [15:0]        dwupb_warn_t;
   typedef logic signed [15:0] dwupb_util_t;
   typedef logic [2:0]         dwupb_slot_t;
endpackage : dwupb_pkg

// ### verilog/dwupb_latch_bit.sv
`timescale 1ns/1ps
module dwupb_latch_bit #(
   parameter bit AUTO_CLEAR = 1'b0,
   parameter bit VALID      = 1'b1
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   input  wire logic cond_in,
   input  wire logic fault_reset_in,
   output logic      present_out,
   output logic      sticky_out
);
   logic cond_v;
   logic hold;
   logic latch_d;
   logic latch_q;

   assign cond_v      = VALID & cond_in;
   // condition wins over a simultaneous fault reset so no event is lost
   assign hold        = ~fault_reset_in & (~AUTO_CLEAR | cond_v);
   assign latch_d     = cond_v | (latch_q & hold);
   assign present_out = cond_v;
   assign sticky_out  = latch_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         latch_q <= 1'b0;
      end else if (ce_in) begin
         latch_q <= latch_d;
      end
   end
endmodule : dwupb_latch_bit

// ### verilog/dwupb_param_bank.sv
`timescale 1ns/1ps
`include "dwupb_defines.svh"
module dwupb_param_bank (
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  ce_in,
   input  wire dwupb_pkg::dwupb_addr_t param_addr_in,
   input  wire logic                  param_rd_in,
   input  wire logic                  param_wr_in,
   input  wire dwupb_pkg::dwupb_word_t param_wdata_in,
   output dwupb_pkg::dwupb_word_t      param_rdata_out,
   output logic                       param_ack_out,
   output logic                       param_err_out,
   input  wire logic                  restore_valid_in,
   input  wire dwupb_pkg::dwupb_slot_t restore_slot_in,
   input  wire dwupb_pkg::dwupb_word_t restore_data_in,
   output dwupb_pkg::dwupb_word_t      user_word_1_out,
   output dwupb_pkg::dwupb_word_t      user_word_2_out,
   output dwupb_pkg::dwupb_word_t      user_word_3_out,
   output dwupb_pkg::dwupb_word_t      user_word_4_out,
   output logic                       homing_required_out,
   input  wire dwupb_pkg::dwupb_warn_t warn_cond_in,
   input  wire logic                  fault_reset_in,
   input  wire dwupb_pkg::dwupb_util_t volt_util_in,
   input  wire logic                  homing_done_in,
   input  wire logic                  abs_move_req_in,
   output logic                       abs_move_ok_out,
   output logic                       abs_move_reject_out,
   output dwupb_pkg::dwupb_warn_t      present_warn_out,
   output dwupb_pkg::dwupb_warn_t      sticky_warn_out
);
   import dwupb_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   dwupb_word_t user_q [0:3];
   dwupb_word_t user_d [0:3];
   logic        home_req_q;
   logic        home_req_d;
   dwupb_word_t rdata_q;
   dwupb_word_t rdata_d;
   logic        ack_q;
   logic        err_q;
   logic        err_d;
   dwupb_warn_t present_w;
   dwupb_warn_t sticky_w;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic sel_u1;
   logic sel_u2;
   logic sel_u3;
   logic sel_u4;
   logic sel_home;
   logic sel_pres;
   logic sel_stick;
   logic sel_util;
   logic sel_rw;
   logic sel_any;
   logic req;
   logic wr_ok;
   logic home_bad;

   assign sel_u1    = (param_addr_in == `DWUPB_ADDR_USER1);
   assign sel_u2    = (param_addr_in == `DWUPB_ADDR_USER2);
   assign sel_u3    = (param_addr_in == `DWUPB_ADDR_USER3);
   assign sel_u4    = (param_addr_in == `DWUPB_ADDR_USER4);
   assign sel_home  = (param_addr_in == `DWUPB_ADDR_HOME_REQ);
   assign sel_pres  = (param_addr_in == `DWUPB_ADDR_PRESENT);
   assign sel_stick = (param_addr_in == `DWUPB_ADDR_STICKY);
   assign sel_util  = (param_addr_in == `DWUPB_ADDR_VOLT_UTIL);
   assign sel_rw    = sel_u1 | sel_u2 | sel_u3 | sel_u4 | sel_home;
   assign sel_any   = sel_rw | sel_pres | sel_stick | sel_util;
   assign req       = param_rd_in | param_wr_in;
   // flag accepts only 0 or 1; anything larger is refused unchanged
   assign home_bad  = sel_home & (param_wdata_in > `DWUPB_HOME_REQ_MAX);
   assign wr_ok     = param_wr_in & sel_rw & ~home_bad;

   // ---------------------------------------------------------------
   // writable parameters
   // ---------------------------------------------------------------
   logic [3:0] u_wr;
   logic [3:0] u_rs;

   assign u_wr = {sel_u4, sel_u3, sel_u2, sel_u1} & {4{wr_ok}};
   assign u_rs[0] = restore_valid_in & (restore_slot_in == `DWUPB_SLOT_USER1);
   assign u_rs[1] = restore_valid_in & (restore_slot_in == `DWUPB_SLOT_USER2);
   assign u_rs[2] = restore_valid_in & (restore_slot_in == `DWUPB_SLOT_USER3);
   assign u_rs[3] = restore_valid_in & (restore_slot_in == `DWUPB_SLOT_USER4);

   // fieldbus write wins over a simultaneous restore from storage
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_user
         assign user_d[gi] = u_wr[gi] ? param_wdata_in :
                             u_rs[gi] ? restore_data_in : user_q[gi];
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               user_q[gi] <= `DWUPB_RST_USER;
            end else if (ce_in) begin
               user_q[gi] <= user_d[gi];
            end
         end
      end
   endgenerate

   logic home_rs;
   assign home_rs    = restore_valid_in &
                       (restore_slot_in == `DWUPB_SLOT_HOME_REQ);
   assign home_req_d = (wr_ok & sel_home) ? param_wdata_in[0] :
                       home_rs ? restore_data_in[0] : home_req_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         home_req_q <= `DWUPB_RST_HOME_REQ;
      end else if (ce_in) begin
         home_req_q <= home_req_d;
      end
   end

   // ---------------------------------------------------------------
   // warning bits
   // ---------------------------------------------------------------
   // one cell per bit; the masks fix the bit map and self-clear set
   localparam dwupb_warn_t AUTO_MASK  = `DWUPB_WARN_AUTO_MASK;
   localparam dwupb_warn_t VALID_MASK = `DWUPB_WARN_VALID_MASK;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_warn
         dwupb_latch_bit #(
            .AUTO_CLEAR (AUTO_MASK[gi]),
            .VALID      (VALID_MASK[gi])
         ) u_bit (
            .clk_in         (clk_in),
            .rst_n_in       (rst_n_in),
            .ce_in          (ce_in),
            .cond_in        (warn_cond_in[gi]),
            .fault_reset_in (fault_reset_in),
            .present_out    (present_w[gi]),
            .sticky_out     (sticky_w[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // absolute positioning gate
   // ---------------------------------------------------------------
   // homing_done_in is owned by the motion core; only gated here
   logic abs_allowed;
   assign abs_allowed = ~home_req_q | homing_done_in;
   assign abs_move_ok_out     = abs_move_req_in & abs_allowed;
   assign abs_move_reject_out = abs_move_req_in & ~abs_allowed;

   // ---------------------------------------------------------------
   // read mux and answer
   // ---------------------------------------------------------------
   dwupb_word_t util_ext;
   assign util_ext = {{16{volt_util_in[15]}}, volt_util_in};

   assign rdata_d =
      ~(param_rd_in & sel_any) ? rdata_q :
      sel_u1    ? user_q[0] :
      sel_u2    ? user_q[1] :
      sel_u3    ? user_q[2] :
      sel_u4    ? user_q[3] :
      sel_home  ? {31'h0000_0000, home_req_q} :
      sel_pres  ? {16'h0000, present_w} :
      sel_stick ? {16'h0000, sticky_w} :
      util_ext;

   // reads of unknown parameters and writes of unknown or read-only parameters answer err
   assign err_d = (param_rd_in & ~sel_any) |
                  (param_wr_in & (~sel_rw | home_bad));

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0000_0000;
         ack_q   <= 1'b0;
         err_q   <= 1'b0;
      end else if (ce_in) begin
         rdata_q <= rdata_d;
         ack_q   <= req;
         err_q   <= req & err_d;
      end
   end

   assign param_rdata_out     = rdata_q;
   assign param_ack_out       = ack_q;
   assign param_err_out       = err_q;
   assign user_word_1_out     = user_q[0];
   assign user_word_2_out     = user_q[1];
   assign user_word_3_out     = user_q[2];
   assign user_word_4_out     = user_q[3];
   assign homing_required_out = home_req_q;
   assign present_warn_out    = present_w;
   assign sticky_warn_out     = sticky_w;
endmodule : dwupb_param_bank
